// ---- rtl/sbcd_decode.sv ----
`timescale 1ns/1ps
module sbcd_decode
  import sbcd_pkg::*;
(
  // fuse bytes and strap word
  input wire logic [7:0] i_byte0,
  input wire logic [7:0] i_byte1,
  input wire logic i_secure,
  input wire logic [SBCD_STRAP_W-1:0] i_strap,
  // decoded settings
  output sbcd_sec_s o_sec,
  output sbcd_clk_s o_clk
);

  logic [1:0] refsel;
  logic f7;
  logic f5;

  always_comb begin
    o_sec = '0;
    if (i_secure) begin
      o_sec.secure_world_en = i_byte0[SBCD_B0_SECURE_WORLD_BIT];
      o_sec.debug_blocked = i_byte1[SBCD_B1_DEBUG_BLOCK_BIT];
      o_sec.auth_required = i_byte1[SBCD_B1_AUTH_BIT];
      o_sec.key_size = sbcd_keysz_e'(i_byte1[SBCD_B1_KEYSZ_LSB +: 2]);
      o_sec.key_is_hash = i_byte1[SBCD_B1_KEYPKG_BIT];
    end
  end

  assign refsel = i_strap[SBCD_ST_REFSEL_LSB +: 2];
  assign f7 = i_strap[SBCD_ST_FREQ_BIT];
  assign f5 = i_strap[SBCD_ST_FREQ_ALIAS_BIT];

  always_comb begin
    o_clk.pll_enable = i_strap[SBCD_ST_PLL_BIT];
    o_clk.ref_xtal_sel = (refsel == SBCD_REFSEL_XTAL);
    o_clk.ref_24mhz = o_clk.ref_xtal_sel && f7 && f5;
    o_clk.ref_48mhz = o_clk.ref_xtal_sel && !f7 && !f5;
    o_clk.strap_error = !o_clk.ref_xtal_sel || (f5 != f7);
  end

endmodule : sbcd_decode

// ---- rtl/sbcd_pkg.sv ----
package sbcd_pkg;

  // fuse byte 0 fields
  localparam int SBCD_B0_SECURE_WORLD_BIT = 1;
  // fuse byte 1 fields
  localparam int SBCD_B1_DEBUG_BLOCK_BIT = 0;
  localparam int SBCD_B1_AUTH_BIT = 1;
  localparam int SBCD_B1_KEYSZ_LSB = 2;
  localparam int SBCD_B1_KEYPKG_BIT = 4;
  // strap fields
  localparam int SBCD_STRAP_W = 22;
  localparam int SBCD_ST_FREQ_ALIAS_BIT = 5;
  localparam int SBCD_ST_FREQ_BIT = 7;
  localparam int SBCD_ST_REFSEL_LSB = 8;
  localparam int SBCD_ST_SECURE_BIT = 17;
  localparam int SBCD_ST_PLL_BIT = 21;
  localparam logic [1:0] SBCD_REFSEL_XTAL = 2'h3;
  // fuse addresses
  localparam logic [7:0] SBCD_FUSE_ADDR0 = 8'h00;
  localparam logic [7:0] SBCD_FUSE_ADDR1 = 8'h01;
  // register bus map
  localparam logic [7:0] SBCD_OFS_STATUS = 8'h00;
  localparam logic [7:0] SBCD_OFS_FUSE = 8'h04;
  localparam logic [7:0] SBCD_OFS_STRAP = 8'h08;
  localparam logic [7:0] SBCD_OFS_CTRL = 8'h0C;
  localparam logic SBCD_CTRL_RESET = 1'b0;
  // reset hold: 10 us at 40 MHz
  localparam int SBCD_RST_HOLD_NS = 10000;
  localparam int SBCD_CLK_PERIOD_NS = 25;
  localparam int SBCD_RST_HOLD_CYC = (SBCD_RST_HOLD_NS + SBCD_CLK_PERIOD_NS - 1)
                                     / SBCD_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SBCD_KEY_NA = 2'h0,
    SBCD_KEY_1K = 2'h1,
    SBCD_KEY_2K = 2'h2,
    SBCD_KEY_4K = 2'h3
  } sbcd_keysz_e;

  typedef struct packed {
    logic secure_world_en;
    logic debug_blocked;
    logic auth_required;
    sbcd_keysz_e key_size;
    logic key_is_hash;
  } sbcd_sec_s;

  typedef struct packed {
    logic pll_enable;
    logic ref_24mhz;
    logic ref_48mhz;
    logic ref_xtal_sel;
    logic strap_error;
  } sbcd_clk_s;

endpackage : sbcd_pkg

// ---- rtl/sbcd_top.sv ----
`timescale 1ns/1ps
module sbcd_top
  import sbcd_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // straps from pins
  input wire logic [SBCD_STRAP_W-1:0] i_expansion_addr_strap,
  // fuse array read port
  output logic o_fuse_rd,
  output logic [7:0] o_fuse_addr,
  input wire logic i_fuse_valid,
  input wire logic [7:0] i_fuse_data,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // decoded settings
  output sbcd_sec_s o_sec,
  output sbcd_clk_s o_clk,
  output logic o_config_done
);

  typedef enum logic [1:0] {
    SBCD_ST_IDLE = 2'b00,
    SBCD_ST_RD0 = 2'b01,
    SBCD_ST_RD1 = 2'b11,
    SBCD_ST_DONE = 2'b10
  } sbcd_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // strap synchroniser
  logic [SBCD_STRAP_W-1:0] strap_s1_r;
  logic [SBCD_STRAP_W-1:0] strap_s2_r;

  always_ff @(posedge i_clock) begin
    strap_s1_r <= i_expansion_addr_strap;
    strap_s2_r <= strap_s1_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fuse read sequencer
  sbcd_state_e state_r, state_nxt;
  logic [7:0] byte0_r, byte0_nxt;
  logic [7:0] byte1_r, byte1_nxt;
  logic [SBCD_STRAP_W-1:0] strap_r, strap_nxt;
  logic secure_r, secure_nxt;
  logic [1:0] settle_r, settle_nxt;
  sbcd_sec_s sec_dec;
  sbcd_clk_s clk_dec;
  sbcd_sec_s sec_r, sec_nxt;
  sbcd_clk_s clk_r, clk_nxt;

  always_comb begin
    state_nxt = state_r;
    byte0_nxt = byte0_r;
    byte1_nxt = byte1_r;
    strap_nxt = strap_r;
    secure_nxt = secure_r;
    settle_nxt = settle_r;
    sec_nxt = sec_r;
    clk_nxt = clk_r;
    case (state_r)
      SBCD_ST_IDLE: begin
        // wait for the strap synchroniser to fill
        if (settle_r == 2'h3) begin
          strap_nxt = strap_s2_r;
          secure_nxt = strap_s2_r[SBCD_ST_SECURE_BIT];
          state_nxt = strap_s2_r[SBCD_ST_SECURE_BIT] ? SBCD_ST_RD0 : SBCD_ST_DONE;
        end else begin
          settle_nxt = settle_r + 2'h1;
        end
      end
      SBCD_ST_RD0: begin
        if (i_fuse_valid) begin
          byte0_nxt = i_fuse_data;
          state_nxt = SBCD_ST_RD1;
        end
      end
      SBCD_ST_RD1: begin
        if (i_fuse_valid) begin
          byte1_nxt = i_fuse_data;
          state_nxt = SBCD_ST_DONE;
        end
      end
      SBCD_ST_DONE: begin
      end
      default: state_nxt = SBCD_ST_IDLE;
    endcase
    if (state_r != SBCD_ST_DONE && state_nxt == SBCD_ST_DONE) begin
      sec_nxt = '0;
      clk_nxt = '0;
    end
    if (state_r == SBCD_ST_DONE && !o_config_done) begin
      // latch once, hold until reset
      sec_nxt = sec_dec;
      clk_nxt = clk_dec;
    end
  end

  logic done_r, done_nxt;
  assign done_nxt = done_r | (state_r == SBCD_ST_DONE);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= SBCD_ST_IDLE;
      byte0_r <= 8'h00;
      byte1_r <= 8'h00;
      strap_r <= '0;
      secure_r <= 1'b0;
      settle_r <= 2'h0;
      sec_r <= '0;
      clk_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      byte0_r <= byte0_nxt;
      byte1_r <= byte1_nxt;
      strap_r <= strap_nxt;
      secure_r <= secure_nxt;
      settle_r <= settle_nxt;
      sec_r <= sec_nxt;
      clk_r <= clk_nxt;
      done_r <= done_nxt;
    end
  end

  sbcd_decode u_decode (
    .i_byte0(byte0_r),
    .i_byte1(byte1_r),
    .i_secure(secure_r),
    .i_strap(strap_r),
    .o_sec(sec_dec),
    .o_clk(clk_dec)
  );

  assign o_fuse_rd = (state_r == SBCD_ST_RD0) || (state_r == SBCD_ST_RD1);
  assign o_fuse_addr = (state_r == SBCD_ST_RD1) ? SBCD_FUSE_ADDR1 : SBCD_FUSE_ADDR0;
  assign o_config_done = done_r;
  assign o_sec = sec_r;
  assign o_clk = clk_r;

  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave
  logic aph_wr_r, aph_wr_nxt;
  logic [7:0] aph_addr_r, aph_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic ctrl_r, ctrl_nxt;
  logic take;

  assign take = i_hsel && i_hready && i_htrans[1];

  always_comb begin
    aph_wr_nxt = take && i_hwrite;
    aph_addr_nxt = take ? i_haddr : aph_addr_r;
    ctrl_nxt = ctrl_r;
    if (aph_wr_r && aph_addr_r == SBCD_OFS_CTRL && !done_r) begin
      // scratch control bit, written only before capture closes
      ctrl_nxt = i_hwdata[0];
    end
    hrdata_nxt = 32'h0000_0000;
    if (take && !i_hwrite) begin
      case (i_haddr)
        SBCD_OFS_STATUS: hrdata_nxt = {24'h00_0000, 2'h0, state_r, clk_r.strap_error,
                                       secure_r, ctrl_r, done_r};
        SBCD_OFS_FUSE: hrdata_nxt = {16'h0000, byte1_r, byte0_r};
        SBCD_OFS_STRAP: hrdata_nxt = {10'h000, strap_r};
        SBCD_OFS_CTRL: hrdata_nxt = {22'h00_0000, sec_r, clk_r[4:2], ctrl_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aph_wr_r <= 1'b0;
      aph_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      ctrl_r <= SBCD_CTRL_RESET;
    end else begin
      aph_wr_r <= aph_wr_nxt;
      aph_addr_r <= aph_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  a_settings_held: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && $past(done_r) |-> $stable(sec_r) && $stable(clk_r))
    else $error("settings changed after capture");
  a_sec_zero_nonsecure: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && !secure_r |-> sec_r == '0)
    else $error("security set without secure boot");
  a_world_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && secure_r |-> sec_r.secure_world_en == byte0_r[1])
    else $error("secure world mismatch");
  a_debug_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && secure_r |-> sec_r.debug_blocked == byte1_r[0])
    else $error("debug block mismatch");
  a_auth_bit: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && secure_r |-> sec_r.auth_required == byte1_r[1])
    else $error("auth mismatch");
  a_key_fields: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && secure_r |-> sec_r.key_size == byte1_r[3:2] && sec_r.key_is_hash == byte1_r[4])
    else $error("key field mismatch");
  a_pll_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r |-> clk_r.pll_enable == strap_r[21])
    else $error("pll select mismatch");
  a_ref_freq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r |-> clk_r.ref_24mhz == (strap_r[9:8] == 2'h3 && strap_r[7] && strap_r[5])
    && !(clk_r.ref_24mhz && clk_r.ref_48mhz))
    else $error("reference frequency mismatch");
  a_refsel_err: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r |-> clk_r.strap_error == (strap_r[9:8] != 2'h3 || strap_r[5] != strap_r[7]))
    else $error("strap error mismatch");
  a_fuse_two_reads: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state_r == SBCD_ST_RD0 && i_fuse_valid |=> state_r == SBCD_ST_RD1 && o_fuse_addr == 8'h01)
    else $error("second fuse read missing");

  c_secure_boot: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_r) && secure_r);
  c_plain_boot: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_r) && !secure_r);
  c_ref_24: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && clk_r.ref_24mhz);
  c_ref_48: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    done_r && clk_r.ref_48mhz);

endmodule : sbcd_top

// ---- tb/sbcd_fuse_model.sv ----
`timescale 1ns/1ps
module sbcd_fuse_model
  import sbcd_pkg::*;
(
  // clock and read request
  input wire logic i_clock,
  input wire logic i_fuse_rd,
  input wire logic [7:0] i_fuse_addr,
  // stored bytes and answer delay
  input wire logic [7:0] i_byte0,
  input wire logic [7:0] i_byte1,
  input wire logic [3:0] i_lat,
  // answer
  output logic o_fuse_valid,
  output logic [7:0] o_fuse_data
);
  logic [3:0] cnt_r = 4'h0;
  initial begin
    o_fuse_valid = 1'b0;
    o_fuse_data = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one pulse per byte after i_lat waits, data scrambled outside it
  always @(posedge i_clock) begin
    if (i_fuse_rd && !o_fuse_valid && cnt_r >= i_lat) begin
      o_fuse_valid <= 1'b1;
      o_fuse_data <= (i_fuse_addr == SBCD_FUSE_ADDR1) ? i_byte1 : i_byte0;
      cnt_r <= 4'h0;
    end else begin
      o_fuse_valid <= 1'b0;
      o_fuse_data <= ~o_fuse_data;
      cnt_r <= (i_fuse_rd && !o_fuse_valid) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : sbcd_fuse_model

// ---- tb/secure_boot_config_decoder_bench.sv ----
`timescale 1ns/1ps
module secure_boot_config_decoder_bench;
  import sbcd_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [SBCD_STRAP_W-1:0] strap = '0;
  logic hsel = 1'b0, hwrite = 1'b0, rd_dph = 1'b0, done_d = 1'b0;
  logic [7:0] haddr = 8'h00, fb0 = 8'h00, fb1 = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, xs_r = 32'd76895;
  logic [3:0] lat = 4'h0;
  logic fuse_rd, fuse_valid, hready, hresp, done;
  logic [7:0] fuse_addr, fuse_data;
  logic [31:0] hrdata;
  sbcd_sec_s sec;
  sbcd_clk_s clk;
  logic [10:0] held_r = '0;
  logic [10:0] cfg_q[$];
  logic [31:0] rd_q[$];
  int failures = 0;
  int n_checks = 0;
  always #12.5 i_clock = ~i_clock;
  ////////////////////////////////////////////////////////////////////////////
  sbcd_top dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_expansion_addr_strap(strap),
    .o_fuse_rd(fuse_rd), .o_fuse_addr(fuse_addr), .i_fuse_valid(fuse_valid),
    .i_fuse_data(fuse_data), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_sec(sec), .o_clk(clk),
    .o_config_done(done));
  sbcd_fuse_model fuse_u (.i_clock(i_clock), .i_fuse_rd(fuse_rd), .i_fuse_addr(fuse_addr),
    .i_byte0(fb0), .i_byte1(fb1), .i_lat(lat), .o_fuse_valid(fuse_valid),
    .o_fuse_data(fuse_data));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    xs_r ^= xs_r << 13;
    xs_r ^= xs_r >> 17;
    xs_r ^= xs_r << 5;
    return xs_r;
  endfunction : next_rand
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge i_clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dph <= !wr;
    if (!wr) rd_q.push_back(exp);
    do @(posedge i_clock); while (hready !== 1'b1);
    rd_dph <= 1'b0;
  endtask : bus
  ////////////////////////////////////////////////////////////////////////////
  // result monitor
  always @(posedge i_clock) begin
    done_d <= done;
    if (done && !done_d) begin
      held_r <= {sec, clk};
      check({21'h0, sec, clk}, {21'h0, cfg_q.pop_front()}, "settings");
    end
    if (done && done_d) check({21'h0, sec, clk}, {21'h0, held_r}, "settings held");
    if (rd_dph) check(hrdata, rd_q.pop_front(), "read data");
    if (rd_dph) check({31'h0, hresp}, 32'h0, "response");
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input logic [21:0] st, input logic [7:0] b0, input logic [7:0] b1);
    logic s;
    logic err;
    logic [31:0] r;
    logic [10:0] cfg;
    s = st[SBCD_ST_SECURE_BIT];
    err = (st[9:8] != SBCD_REFSEL_XTAL) || (st[5] != st[7]);
    r = next_rand();
    i_rst_n <= 1'b0;
    strap <= st;
    fb0 <= b0;
    fb1 <= b1;
    lat <= r[3:0];
    repeat (SBCD_RST_HOLD_CYC) @(posedge i_clock);
    cfg = {s & b0[1], s & b1[0], s & b1[1], s ? b1[3:2] : 2'h0, s & b1[4],
      st[SBCD_ST_PLL_BIT], !err & st[7], !err & !st[7], st[9:8] == SBCD_REFSEL_XTAL, err};
    cfg_q.push_back(cfg);
    i_rst_n <= 1'b1;
    // scratch write lands before capture closes
    bus(1'b1, SBCD_OFS_CTRL, 32'h1, 32'h0);
    for (int k = 0; k < 200 && done !== 1'b1; k++) @(posedge i_clock);
    check({31'h0, done}, 32'h1, "config done");
    repeat (3) @(posedge i_clock);
    bus(1'b0, SBCD_OFS_STRAP, 32'h0, {10'h0, st});
    if (s) bus(1'b0, SBCD_OFS_FUSE, 32'h0, {16'h0, b1, b0});
    bus(1'b1, 8'h10, r, 32'h0);
    bus(1'b0, 8'h10, 32'h0, 32'h0);
    // scratch write after capture is ignored
    bus(1'b1, SBCD_OFS_CTRL, 32'h0, 32'h0);
    bus(1'b0, SBCD_OFS_CTRL, 32'h0, {22'h0, cfg[10:2], 1'b1});
    bus(1'b0, SBCD_OFS_STATUS, 32'h0, {26'h0, 2'h2, err, s, 1'b1, 1'b1});
    $display("test done strap %h fuse %h %h", st, b0, b1);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [21:0] st;
    logic [7:0] b1;
    for (int i = 0; i < 8; i++) begin
      r = next_rand();
      st = r[21:0];
      st[SBCD_ST_SECURE_BIT] = (i != 4);
      st[9:8] = (i >= 5) ? 2'(i - 5) : SBCD_REFSEL_XTAL;
      st[7] = i[0];
      st[5] = (i == 3) ? !st[7] : st[7];
      b1 = r[31:24];
      b1[3:2] = i[1:0];
      run(st, r[29:22], b1);
    end
    repeat (4) @(posedge i_clock);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    failures++;
    summarize();
  end
endmodule : secure_boot_config_decoder_bench
